// *** verilog/esdc_consts.vh ***
// constants of the engine shutdown control block
`ifndef ESDC_CONSTS_VH
`define ESDC_CONSTS_VH

// register offsets (byte addresses)
`define ESDC_REG_CTRL 8'h00
`define ESDC_REG_OVSPD 8'h04
`define ESDC_REG_STATUS 8'h08
`define ESDC_REG_IRQ_STAT 8'h0C
`define ESDC_REG_IRQ_MASK 8'h10
`define ESDC_REG_SPEED 8'h14

// control field positions
`define ESDC_CTRL_AIR_EN 0

// status field positions
`define ESDC_ST_FUEL_DIS 0
`define ESDC_ST_REMOTE_LATCH 1
`define ESDC_ST_OVSPD_LATCH 2
`define ESDC_ST_AIR_SHUTOFF 3
`define ESDC_ST_LINK_SHUT 4
`define ESDC_ST_ROTATING 5

// event bit positions
`define ESDC_EV_REMOTE 0
`define ESDC_EV_OVSPD 1
`define ESDC_EV_LINK_SHUT 2
`define ESDC_EV_LINK_RUN 3
`define ESDC_EV_LINK_TMO 4
`define ESDC_EV_RELEASE_ROT 5
`define ESDC_EV_W 6

// reset values
`define ESDC_CTRL_RST 1'b0
`define ESDC_OVSPD_RST 16'h0BB8
`define ESDC_MASK_RST 6'h00

// timing: link request timeout
`define ESDC_CLK_HZ 125000000
`define ESDC_LINK_TMO_S 3
`define ESDC_LINK_TMO_CYC (`ESDC_CLK_HZ * `ESDC_LINK_TMO_S)
`define ESDC_TICK_MS_NS 1000000
`define ESDC_CLK_NS 8
`define ESDC_TICK_CYC (`ESDC_TICK_MS_NS / `ESDC_CLK_NS)
`define ESDC_TMO_MS (`ESDC_LINK_TMO_S * 1000)

// overspeed verify threshold: 75 percent as 3/4
`define ESDC_VERIFY_NUM 3
`define ESDC_VERIFY_SHIFT 2

`endif

// *** verilog/esdc_tick_div.v ***
// millisecond tick divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module esdc_tick_div #(
   parameter DIV = 125000
)
(
   // clock and reset
   input wire clk_sys_i,
   input wire rst_n_i,
   // tick out
   output reg tick_o
);

   reg [31:0] cnt_q;

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 32'h0;
         tick_o <= 1'b0;
      end
      else if (cnt_q == DIV - 1)
      begin
         cnt_q <= 32'h0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 32'h1;
         tick_o <= 1'b0;
      end
   end

endmodule // esdc_tick_div

// *** verilog/esdc_top.v ***
// engine shutdown control: remote switch, overspeed air shutoff, link request
`timescale 1ns/1ps
`include "esdc_consts.vh"

module esdc_top #(
   parameter TICK_CYC = `ESDC_TICK_CYC
)
(
   // clock and reset (reset also marks switched power cycling)
   input wire clk_sys_i,
   input wire rst_n_i,
   // engine pins
   input wire remote_shut_n_i,
   input wire ovspd_verify_i,
   input wire [15:0] engine_rpm_i,
   // link request: one-cycle strobe with commanded state
   input wire link_req_i,
   input wire link_shutdown_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // outputs
   output reg fuel_disable_o,
   output reg air_shutoff_o,
   output reg irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // registers and state

   reg air_en_q;
   reg [15:0] ovspd_q;
   reg [5:0] irq_stat_q;
   reg [5:0] irq_mask_q;
   reg remote_latch_q;
   reg ovspd_latch_q;
   reg link_shut_q;
   reg [11:0] tmo_ms_q;
   reg remote_prev_q;
   reg remote_latch_d;
   reg ovspd_latch_d;
   reg link_shut_d;
   reg [11:0] tmo_ms_d;
   reg fuel_disable_d;
   reg air_shutoff_d;
   reg [5:0] irq_stat_d;
   reg [31:0] reg_rdata_d;
   wire tick;
   wire remote_on;
   wire rotating;
   wire [17:0] thr_full;
   wire [17:0] thr_verify;
   wire [17:0] threshold;
   wire overspeed;
   wire [5:0] ev;
   wire link_tmo;
   wire [31:0] thr_scaled;
   wire wr_ctrl;
   wire wr_ovspd;
   wire wr_irq_stat;
   wire wr_irq_mask;
   wire [5:0] status_vec;

   // link request state codes
   localparam LINK_RUN = 1'b0;
   localparam LINK_SHUT = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick

   esdc_tick_div #(
      .DIV(TICK_CYC)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // remote shutdown switch

   assign remote_on = ~remote_shut_n_i;
   assign rotating = (engine_rpm_i != 16'h0000);

   // once seen, the switch keeps injection off until power is cycled
   always @*
   begin
      remote_latch_d = remote_latch_q;
      if (remote_on)
      begin
         remote_latch_d = 1'b1;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         remote_latch_q <= 1'b0;
         remote_prev_q <= 1'b0;
      end
      else
      begin
         remote_prev_q <= remote_on;
         remote_latch_q <= remote_latch_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overspeed with verify threshold

   assign thr_full = {2'b00, ovspd_q};
   assign thr_scaled = (thr_full * `ESDC_VERIFY_NUM) >> `ESDC_VERIFY_SHIFT;
   // three quarters of a 16-bit limit always fits the 18-bit compare path
   assign thr_verify = thr_scaled[17:0];
   assign threshold = ovspd_verify_i ? thr_verify : thr_full;
   assign overspeed = ({2'b00, engine_rpm_i} > threshold);

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         ovspd_latch_q <= 1'b0;
      end
      else
      begin
         ovspd_latch_q <= ovspd_latch_d;
      end
   end

   // a crossing of the threshold stays latched until power is cycled
   always @*
   begin
      ovspd_latch_d = ovspd_latch_q;
      if (overspeed)
      begin
         ovspd_latch_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link shutdown request with timeout

   assign link_tmo = link_shut_q && !link_req_i && tick &&
                     (tmo_ms_q == `ESDC_TMO_MS - 1);

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         link_shut_q <= LINK_RUN;
         tmo_ms_q <= 12'h000;
      end
      else
      begin
         link_shut_q <= link_shut_d;
         tmo_ms_q <= tmo_ms_d;
      end
   end

   // next link state: each request restarts the silence timeout
   always @*
   begin
      link_shut_d = link_shut_q;
      tmo_ms_d = tmo_ms_q;
      case (link_shut_q)
         LINK_RUN:
         begin
            if (link_req_i)
            begin
               link_shut_d = link_shutdown_i;
               tmo_ms_d = 12'h000;
            end
         end
         LINK_SHUT:
         begin
            if (link_req_i)
            begin
               link_shut_d = link_shutdown_i;
               tmo_ms_d = 12'h000;
            end
            else if (link_tmo)
            begin
               link_shut_d = LINK_RUN;
               tmo_ms_d = 12'h000;
            end
            else if (tick)
            begin
               tmo_ms_d = tmo_ms_q + 12'h001;
            end
         end
         default:
         begin
            link_shut_d = LINK_RUN;
            tmo_ms_d = 12'h000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // the manual damper switch is outside this logic, so it raises no event

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         fuel_disable_o <= 1'b0;
         air_shutoff_o <= 1'b0;
      end
      else
      begin
         fuel_disable_o <= fuel_disable_d;
         air_shutoff_o <= air_shutoff_d;
      end
   end

   // the solenoid only follows the overspeed path and stays on once fired
   always @*
   begin
      fuel_disable_d = remote_latch_q | remote_on | ovspd_latch_q | overspeed
                       | link_shut_q;
      air_shutoff_d = air_shutoff_o;
      if ((ovspd_latch_q | overspeed) && air_en_q)
      begin
         air_shutoff_d = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events and interrupt

   assign ev[`ESDC_EV_REMOTE] = remote_on && !remote_prev_q;
   assign ev[`ESDC_EV_OVSPD] = overspeed && !ovspd_latch_q;
   assign ev[`ESDC_EV_LINK_SHUT] = link_req_i && link_shutdown_i && !link_shut_q;
   assign ev[`ESDC_EV_LINK_RUN] = link_req_i && !link_shutdown_i && link_shut_q;
   assign ev[`ESDC_EV_LINK_TMO] = link_tmo;
   assign ev[`ESDC_EV_RELEASE_ROT] = !remote_on && remote_prev_q && rotating;
   assign wr_irq_stat = reg_wr_i && (reg_addr_i == `ESDC_REG_IRQ_STAT);

   // write one to clear; an event in the clearing cycle wins
   always @*
   begin
      irq_stat_d = irq_stat_q | ev;
      if (wr_irq_stat)
      begin
         irq_stat_d = (irq_stat_q & ~reg_wdata_i[5:0]) | ev;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         irq_stat_q <= 6'h00;
         irq_o <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port

   // unmapped addresses decode to nothing, so such writes are dropped
   assign wr_ctrl = reg_wr_i && (reg_addr_i == `ESDC_REG_CTRL);
   assign wr_ovspd = reg_wr_i && (reg_addr_i == `ESDC_REG_OVSPD);
   assign wr_irq_mask = reg_wr_i && (reg_addr_i == `ESDC_REG_IRQ_MASK);

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         air_en_q <= `ESDC_CTRL_RST;
         ovspd_q <= `ESDC_OVSPD_RST;
         irq_mask_q <= `ESDC_MASK_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            air_en_q <= reg_wdata_i[`ESDC_CTRL_AIR_EN];
         end
         if (wr_ovspd)
         begin
            ovspd_q <= reg_wdata_i[15:0];
         end
         if (wr_irq_mask)
         begin
            irq_mask_q <= reg_wdata_i[5:0];
         end
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= 32'h0;
      end
      else if (reg_rd_i)
      begin
         reg_rdata_o <= reg_rdata_d;
      end
      else
      begin
         reg_rdata_o <= 32'h0;
      end
   end

   // read data are looked up here and only registered on a read strobe
   assign status_vec = {rotating, link_shut_q, air_shutoff_o, ovspd_latch_q, remote_latch_q,
                        fuel_disable_o};

   always @*
   begin
      case (reg_addr_i)
         `ESDC_REG_CTRL: reg_rdata_d = {31'h0, air_en_q};
         `ESDC_REG_OVSPD: reg_rdata_d = {16'h0, ovspd_q};
         `ESDC_REG_STATUS: reg_rdata_d = {26'h0, status_vec};
         `ESDC_REG_IRQ_STAT: reg_rdata_d = {26'h0, irq_stat_q};
         `ESDC_REG_IRQ_MASK: reg_rdata_d = {26'h0, irq_mask_q};
         `ESDC_REG_SPEED: reg_rdata_d = {16'h0, engine_rpm_i};
         default: reg_rdata_d = 32'h0;
      endcase
   end

endmodule // esdc_top

// *** sim/esdc_top_asserts.sv ***
// port assertions of the engine shutdown control block
`timescale 1ns/1ps
`include "esdc_consts.vh"
module esdc_top_asserts #(
   parameter TICK_CYC = 125000
)
(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire remote_shut_n_i,
   input wire ovspd_verify_i,
   input wire [15:0] engine_rpm_i,
   input wire link_req_i,
   input wire link_shutdown_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [31:0] reg_rdata_o,
   input wire fuel_disable_o,
   input wire air_shutoff_o,
   input wire irq_o
);
   // shadow of the air shutoff enable bit
   reg air_en_q;
   always @(posedge clk_sys_i)
      if (!rst_n_i)
         air_en_q <= 1'b0;
      else if (reg_wr_i && reg_addr_i == `ESDC_REG_CTRL)
         air_en_q <= reg_wdata_i[`ESDC_CTRL_AIR_EN];
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   property p_rem; !remote_shut_n_i |=> fuel_disable_o; endproperty
   a_rem: assert property (p_rem) else $error("remote stop missed");
   property p_latch; !remote_shut_n_i |=> fuel_disable_o [*8]; endproperty
   a_latch: assert property (p_latch) else $error("remote latch lost");
   property p_noair;
      !remote_shut_n_i && engine_rpm_i == 16'h0000 |=> $stable(air_shutoff_o);
   endproperty
   a_noair: assert property (p_noair) else $error("remote moved solenoid");
   property p_afuel; air_shutoff_o |-> fuel_disable_o; endproperty
   a_afuel: assert property (p_afuel) else $error("solenoid without fuel cut");
   property p_ahold; air_shutoff_o |=> air_shutoff_o; endproperty
   a_ahold: assert property (p_ahold) else $error("solenoid released");
   property p_aen; $rose(air_shutoff_o) |-> $past(air_en_q); endproperty
   a_aen: assert property (p_aen) else $error("solenoid while disabled");
   property p_rst; $rose(rst_n_i) |-> !fuel_disable_o && !air_shutoff_o; endproperty
   a_rst: assert property (p_rst) else $error("not run after reset");
   property p_link; link_req_i && link_shutdown_i ##1 !link_req_i |=> fuel_disable_o; endproperty
   a_link: assert property (p_link) else $error("link stop missed");
   c_rem: cover property ($fell(remote_shut_n_i));
   c_air: cover property ($rose(air_shutoff_o));
   c_run: cover property (link_req_i && !link_shutdown_i);
endmodule // esdc_top_asserts
bind esdc_top esdc_top_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.clk_sys_i, .rst_n_i,
   .remote_shut_n_i, .ovspd_verify_i, .engine_rpm_i, .link_req_i, .link_shutdown_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fuel_disable_o,
   .air_shutoff_o, .irq_o);

// *** sim/esdc_link_model.sv ***
// far-side controller issuing run and shutdown link requests
`timescale 1ns/1ps
module esdc_link_model #(
   parameter PERIOD = 4000
)
(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire shut_i,
   input wire run_i,
   output reg req_o = 1'b0,
   output reg shut_o = 1'b0
);
   localparam [15:0] LAST = PERIOD - 1;
   reg [15:0] cnt_q;
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 16'h0000;
         req_o <= 1'b0;
         shut_o <= 1'b0;
      end
      else if (run_i)
      begin
         req_o <= 1'b1;
         shut_o <= 1'b0;
      end
      else if (shut_i)
      begin
         cnt_q <= (cnt_q == 16'h0000) ? LAST : cnt_q - 16'h0001;
         req_o <= (cnt_q == 16'h0000);
         shut_o <= 1'b1;
      end
      else
      begin
         cnt_q <= 16'h0000;
         req_o <= 1'b0;
         // qualifier is meaningless between requests
         shut_o <= ~shut_o;
      end
   end
endmodule // esdc_link_model

// *** sim/tb_engine_shutdown_control.sv ***
// self-checking bench of the engine shutdown control block
`timescale 1ns/1ps
`include "esdc_consts.vh"
module tb_engine_shutdown_control;
   localparam TK = 4;
   reg clk_sys_i = 1'b0, rst_n_i = 1'b0, remote_shut_n_i = 1'b1, ovspd_verify_i = 1'b0;
   reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, m_shut = 1'b0, m_run = 1'b0;
   reg [15:0] engine_rpm_i = 16'h0000;
   reg [15:0] lim;
   reg [7:0] reg_addr_i = 8'h00;
   reg [31:0] reg_wdata_i = 32'h0, rd_q, seed = 32'h115BD83D;
   wire link_req_i, link_shutdown_i, fuel_disable_o, air_shutoff_o, irq_o;
   wire [31:0] reg_rdata_o;
   integer mismatches = 0, n_compared = 0, cycles = 0, i;
   always #4 clk_sys_i = ~clk_sys_i;
   esdc_top #(.TICK_CYC(TK)) i_dut (.clk_sys_i, .rst_n_i, .remote_shut_n_i, .ovspd_verify_i,
      .engine_rpm_i, .link_req_i, .link_shutdown_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .fuel_disable_o, .air_shutoff_o, .irq_o);
   esdc_link_model #(.PERIOD(1000 * TK)) i_link (.clk_sys_i, .rst_n_i, .shut_i(m_shut),
      .run_i(m_run), .req_o(link_req_i), .shut_o(link_shutdown_i));
   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function [15:0] thr(input [15:0] lim, input ver);
      thr = ver ? (lim * 16'h0003) >> 2 : lim;
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (g !== e)
         begin
            mismatches = mismatches + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
         cyc(1);
         reg_wr_i <= 1'b0;
         cyc(1);
      end
   endtask
   task rd(input [7:0] a);
      begin
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         cyc(1);
         reg_rd_i <= 1'b0;
         rd_q = reg_rdata_o;
         cyc(1);
      end
   endtask
   task pwr;
      begin
         rst_n_i <= 1'b0;
         cyc(2);
         rst_n_i <= 1'b1;
         cyc(1);
      end
   endtask
   task tally_and_finish;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   always @(posedge clk_sys_i)
   begin
      cycles = cycles + 1;
      if (cycles == 30000)
      begin
         mismatches = mismatches + 1;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pwr;
      rd(`ESDC_REG_CTRL);
      chk(rd_q, 32'h0);
      wr(8'h1C, 32'hFFFFFFFF);
      rd(8'h1C);
      chk(rd_q, 32'h0);
      for (i = 0; i < 40; i = i + 1)
      begin
         seed = xs(seed);
         ovspd_verify_i <= seed[16];
         engine_rpm_i <= seed[15:0] % (thr(`ESDC_OVSPD_RST, seed[16]) + 16'h0001);
         cyc(2);
         chk(fuel_disable_o, 1'b0);
      end
      ovspd_verify_i <= 1'b0;
      wr(`ESDC_REG_CTRL, 32'h1);
      wr(`ESDC_REG_IRQ_MASK, 32'h20);
      remote_shut_n_i <= 1'b0;
      engine_rpm_i <= 16'h0100;
      cyc(2);
      chk(fuel_disable_o, 1'b1);
      remote_shut_n_i <= 1'b1;
      cyc(3);
      chk({air_shutoff_o, fuel_disable_o}, 2'b01);
      rd(`ESDC_REG_IRQ_STAT);
      chk(rd_q, 32'h21);
      chk(irq_o, 1'b1);
      wr(`ESDC_REG_IRQ_STAT, 32'h21);
      chk(irq_o, 1'b0);
      pwr;
      chk(fuel_disable_o, 1'b0);
      remote_shut_n_i <= 1'b0;
      engine_rpm_i <= 16'h0000;
      cyc(2);
      remote_shut_n_i <= 1'b1;
      rd(`ESDC_REG_IRQ_STAT);
      chk(rd_q, 32'h01);
      pwr;
      wr(`ESDC_REG_CTRL, 32'h1);
      ovspd_verify_i <= 1'b1;
      engine_rpm_i <= thr(`ESDC_OVSPD_RST, 1'b1);
      cyc(3);
      chk(fuel_disable_o, 1'b0);
      engine_rpm_i <= thr(`ESDC_OVSPD_RST, 1'b1) + 16'h0001;
      cyc(2);
      chk({fuel_disable_o, air_shutoff_o}, 2'b11);
      engine_rpm_i <= 16'h0000;
      ovspd_verify_i <= 1'b0;
      cyc(5);
      chk(air_shutoff_o, 1'b1);
      rd(`ESDC_REG_STATUS);
      chk(rd_q, 32'h0D);
      pwr;
      engine_rpm_i <= `ESDC_OVSPD_RST + 16'h0001;
      cyc(2);
      chk({fuel_disable_o, air_shutoff_o}, 2'b10);
      engine_rpm_i <= 16'h0000;
      pwr;
      seed = xs(seed);
      lim = {1'b0, seed[14:0]} | 16'h0004;
      wr(`ESDC_REG_OVSPD, {16'h0000, lim});
      rd(`ESDC_REG_OVSPD);
      chk(rd_q, {16'h0000, lim});
      engine_rpm_i <= lim;
      cyc(2);
      chk(fuel_disable_o, 1'b0);
      engine_rpm_i <= lim + 16'h0001;
      cyc(2);
      rd(`ESDC_REG_SPEED);
      chk(rd_q, {16'h0000, lim + 16'h0001});
      chk(fuel_disable_o, 1'b1);
      engine_rpm_i <= 16'h0000;
      pwr;
      m_shut <= 1'b1;
      cyc(2500 * TK);
      chk(fuel_disable_o, 1'b1);
      m_shut <= 1'b0;
      m_run <= 1'b1;
      cyc(1);
      m_run <= 1'b0;
      cyc(3);
      chk(fuel_disable_o, 1'b0);
      m_shut <= 1'b1;
      cyc(1);
      m_shut <= 1'b0;
      cyc(2990 * TK);
      chk(fuel_disable_o, 1'b1);
      cyc(20 * TK);
      chk(fuel_disable_o, 1'b0);
      rd(`ESDC_REG_IRQ_STAT);
      chk(rd_q, 32'h1C);
      tally_and_finish;
   end
endmodule // tb_engine_shutdown_control
